// file: src/iic_pkg.sv
// Package of constants and types for the isolated input conditioner
package iic_pkg;

    // Channel count and measured voltage width (mV, up to 275000)
    localparam int CHANNELS   = 8;
    localparam int VOLT_W     = 19;
    localparam int LEVEL_W    = 12;
    localparam int DELAY_W    = 22;
    localparam int COUNT_W    = 32;
    localparam int ADDR_W     = 9;

    // Scan timing: the time in ms, the cycle count derived from the clock
    localparam int CLK_HZ         = 20_000_000;
    localparam int SCAN_MS        = 5;
    localparam int SCAN_CYCLES    = CLK_HZ / 1000 * SCAN_MS;
    localparam int AC_EXTRA_MS    = 30;
    localparam int MV_PER_STEP    = 100;
    localparam int AC_MV_PER_STEP = 10;

    // Register offsets inside a channel window, global status word address
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_PICKUP   = 5'h04;
    localparam logic [4:0] OFS_DROPOUT  = 5'h08;
    localparam logic [4:0] OFS_UP_DLY   = 5'h0C;
    localparam logic [4:0] OFS_DOWN_DLY = 5'h10;
    localparam logic [4:0] OFS_COUNT    = 5'h14;
    localparam logic [4:0] OFS_CLEAR    = 5'h18;
    localparam logic [4:0] OFS_VOLT     = 5'h1C;
    localparam logic [8:0] ADR_STATUS   = 9'h100;

    // Control field positions
    localparam int CTRL_NC_BIT    = 0;
    localparam int CTRL_AC_BIT    = 1;
    localparam int CLEAR_BIT      = 0;

    // Reset values: 88.0 V and 60.0 V in 0.1 V steps, no delays
    localparam logic [LEVEL_W-1:0] PICKUP_RESET  = 12'h0370;
    localparam logic [LEVEL_W-1:0] DROPOUT_RESET = 12'h0258;
    localparam logic [DELAY_W-1:0] DELAY_RESET   = 22'h00_0000;

    // Per channel settings
    typedef struct packed {
        logic               nc;
        logic               ac;
        logic [LEVEL_W-1:0] pickup;
        logic [LEVEL_W-1:0] dropout;
        logic [DELAY_W-1:0] up_delay;
        logic [DELAY_W-1:0] down_delay;
    } iic_cfg_type;

    localparam iic_cfg_type CFG_RESET = '{
        nc: 1'b0, ac: 1'b0, pickup: PICKUP_RESET, dropout: DROPOUT_RESET,
        up_delay: DELAY_RESET, down_delay: DELAY_RESET};

endpackage

// file: src/iic_tick.sv
// Scan period tick generator
`timescale 1ns/1ps
module iic_tick
    import iic_pkg::*;
#(
    parameter int CYCLES = SCAN_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // One-cycle pulse per scan period
    output logic      tick
);
    localparam int CW = $clog2(CYCLES);

    logic [CW-1:0] count;

    // Free running divider; restarts at reset so the first scan is a full period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == CW'(CYCLES - 1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + CW'(1);
            tick  <= 1'b0;
        end
    end
endmodule

// file: src/iic_chan.sv
// One input channel: thresholds, polarity, delays and rising-edge counter
`timescale 1ns/1ps
module iic_chan
    import iic_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               nrst,
    // Scan tick and settings
    input  wire logic               tick,
    input  wire iic_cfg_type        cfg,
    input  wire logic [VOLT_W-1:0]  volt,
    input  wire logic               clear,
    // Conditioned state
    output logic                    status,
    output logic [COUNT_W-1:0]      count
);
    logic [VOLT_W:0]   pick_mv;
    logic [VOLT_W:0]   rel_mv;
    logic [DELAY_W-1:0] need;
    logic [DELAY_W-1:0] elapsed;
    logic              energized;
    logic              target;
    logic              rise;

    // Thresholds in mV; AC mode drops to a tenth of the pickup level
    assign pick_mv = (VOLT_W+1)'(cfg.pickup * MV_PER_STEP);
    assign rel_mv  = cfg.ac ? (VOLT_W+1)'(cfg.pickup * AC_MV_PER_STEP)
                            : (VOLT_W+1)'(cfg.dropout * MV_PER_STEP);
    // Polarity turns the energized state into the logical state
    assign target  = energized ^ cfg.nc;
    // Delay of the pending change, AC adds its fixed margin on release
    assign need    = target ? cfg.up_delay
                   : cfg.down_delay + (cfg.ac ? DELAY_W'(AC_EXTRA_MS) : '0);
    assign rise    = tick && target && !status && (elapsed >= need);

    // Raw energized state with hysteresis, re-evaluated once per scan
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            energized <= 1'b0;
        end else if (tick) begin
            if ({1'b0, volt} > pick_mv) begin
                energized <= 1'b1;
            end else if ({1'b0, volt} < rel_mv) begin
                energized <= 1'b0;
            end
        end
    end

    // Delay timer in ms; a change that reverts before expiry is dropped
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            elapsed <= '0;
            status  <= 1'b0;
        end else if (tick) begin
            if (target == status) begin
                elapsed <= '0;
            end else if (elapsed >= need) begin
                elapsed <= '0;
                status  <= target;
            end else begin
                elapsed <= elapsed + DELAY_W'(SCAN_MS);
            end
        end
    end

    // Rising-edge counter; a rise in the clear cycle still counts
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (rise && clear) begin
            count <= COUNT_W'(1);
        end else if (rise) begin
            count <= count + COUNT_W'(1);
        end else if (clear) begin
            count <= '0;
        end
    end
endmodule

// file: src/iic_top.sv
// Eight channel isolated input conditioner with a classic Wishbone slave
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module iic_top
    import iic_pkg::*;
#(
    parameter int N_CH      = CHANNELS,
    parameter int SCAN_CYC  = SCAN_CYCLES
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        nrst,
    // Measured field voltage per channel, mV
    input  wire logic [N_CH-1:0][VOLT_W-1:0] volt_mv,
    // Wishbone classic slave
    input  wire logic                        wb_cyc,
    input  wire logic                        wb_stb,
    input  wire logic                        wb_we,
    input  wire logic [ADDR_W-1:0]           wb_adr,
    input  wire logic [3:0]                  wb_sel,
    input  wire logic [31:0]                 wb_dat_w,
    output logic      [31:0]                 wb_dat_r,
    output logic                             wb_ack,
    // Conditioned channel states
    output logic      [N_CH-1:0]             input_status
);

    // Per channel state and settings
    iic_cfg_type               cfg      [N_CH];
    logic [N_CH-1:0]           clear_req;
    logic [N_CH-1:0]           status_w;
    logic [COUNT_W-1:0]        count_w  [N_CH];
    logic                      tick;

    // Request decode
    logic                      req;
    logic                      wr;
    logic [2:0]                ch;
    logic [4:0]                ofs;
    logic                      in_window;
    logic [31:0]               next_dat_r;

    assign req       = wb_cyc && wb_stb && !wb_ack;
    assign wr        = req && wb_we;
    assign ch        = wb_adr[7:5];
    assign ofs       = wb_adr[4:0];
    assign in_window = !wb_adr[8] && (32'(ch) < N_CH);

    // Byte-lane merge of a write onto a stored word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Scan period source shared by all channels
    iic_tick #(
        .CYCLES (SCAN_CYC)
    ) u_tick (
        .clock (clock),
        .nrst  (nrst),
        .tick  (tick)
    );

    // One conditioner per channel, same logic for all
    for (genvar i = 0; i < N_CH; i++) begin : g_ch
        iic_chan u_chan (
            .clock  (clock),
            .nrst   (nrst),
            .tick   (tick),
            .cfg    (cfg[i]),
            .volt   (volt_mv[i]),
            .clear  (clear_req[i]),
            .status (status_w[i]),
            .count  (count_w[i])
        );
    end

    // Settings writes; each channel keeps its own copy
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < N_CH; i++) begin
                cfg[i] <= CFG_RESET;
            end
        end else if (wr && in_window) begin
            case (ofs)
                OFS_CTRL: begin
                    if (wb_sel[0]) begin
                        cfg[ch].nc <= wb_dat_w[CTRL_NC_BIT];
                        cfg[ch].ac <= wb_dat_w[CTRL_AC_BIT];
                    end
                end
                OFS_PICKUP: begin
                    cfg[ch].pickup <= LEVEL_W'(merge(
                        32'(cfg[ch].pickup), wb_dat_w, wb_sel));
                end
                OFS_DROPOUT: begin
                    cfg[ch].dropout <= LEVEL_W'(merge(
                        32'(cfg[ch].dropout), wb_dat_w, wb_sel));
                end
                OFS_UP_DLY: begin
                    cfg[ch].up_delay <= DELAY_W'(merge(
                        32'(cfg[ch].up_delay), wb_dat_w, wb_sel));
                end
                OFS_DOWN_DLY: begin
                    cfg[ch].down_delay <= DELAY_W'(merge(
                        32'(cfg[ch].down_delay), wb_dat_w, wb_sel));
                end
                default: begin
                end
            endcase
        end
    end

    // Counter clear command, a single-cycle pulse per write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clear_req <= '0;
        end else begin
            clear_req <= '0;
            if (wr && in_window && ofs == OFS_CLEAR && wb_sel[0]
                && wb_dat_w[CLEAR_BIT]) begin
                clear_req[ch] <= 1'b1;
            end
        end
    end

    // Read mux; unmapped words and reserved bits read as zero
    always_comb begin
        next_dat_r = '0;
        if (wb_adr == ADR_STATUS) begin
            next_dat_r = 32'(status_w);
        end else if (in_window) begin
            case (ofs)
                OFS_CTRL: begin
                    next_dat_r[CTRL_NC_BIT] = cfg[ch].nc;
                    next_dat_r[CTRL_AC_BIT] = cfg[ch].ac;
                end
                OFS_PICKUP: begin
                    next_dat_r = 32'(cfg[ch].pickup);
                end
                OFS_DROPOUT: begin
                    next_dat_r = 32'(cfg[ch].dropout);
                end
                OFS_UP_DLY: begin
                    next_dat_r = 32'(cfg[ch].up_delay);
                end
                OFS_DOWN_DLY: begin
                    next_dat_r = 32'(cfg[ch].down_delay);
                end
                OFS_COUNT: begin
                    next_dat_r = count_w[ch];
                end
                OFS_VOLT: begin
                    next_dat_r = 32'(volt_mv[ch]);
                end
                default: begin
                    next_dat_r = '0;
                end
            endcase
        end
    end

    // Acknowledge every request one cycle later, mapped or not
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= '0;
        end else begin
            wb_ack   <= req;
            wb_dat_r <= req ? next_dat_r : '0;
        end
    end

    // Registered copy of the channel states for the output pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            input_status <= '0;
        end else begin
            input_status <= status_w;
        end
    end

endmodule

// file: tb/iic_monitor.sv
// Port checker for the isolated input conditioner
`timescale 1ns/1ps
module iic_monitor
    import iic_pkg::*;
#(
    parameter int N_CH     = CHANNELS,
    parameter int SCAN_CYC = SCAN_CYCLES
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        nrst,
    // Field side
    input  wire logic [N_CH-1:0][VOLT_W-1:0] volt_mv,
    input  wire logic [N_CH-1:0]             input_status,
    // Register bus
    input  wire logic                        wb_cyc,
    input  wire logic                        wb_stb,
    input  wire logic                        wb_we,
    input  wire logic [ADDR_W-1:0]           wb_adr,
    input  wire logic [3:0]                  wb_sel,
    input  wire logic [31:0]                 wb_dat_w,
    input  wire logic [31:0]                 wb_dat_r,
    input  wire logic                        wb_ack
);
    logic [ADDR_W-1:0] adr_q;
    logic              we_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Keep the request so the answer can be tied to what was asked
    always_ff @(posedge clock) begin
        adr_q <= wb_adr;
        we_q  <= wb_we;
    end

    a_ack_follows_req: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("request not answered in one cycle");
    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("acknowledge longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc && wb_stb) |=> !wb_ack)
        else $error("acknowledge without request");
    a_rdata_idle: assert property (!wb_ack |-> wb_dat_r == '0)
        else $error("read data not zero outside acknowledge");
    a_volt_readback: assert property (wb_ack && !we_q && !adr_q[8]
        && adr_q[4:0] == OFS_VOLT |-> wb_dat_r == 32'(volt_mv[adr_q[7:5]]))
        else $error("measured voltage read back wrong");
    a_status_word: assert property (wb_ack && !we_q && adr_q == ADR_STATUS
        |-> wb_dat_r == 32'(input_status))
        else $error("status word disagrees with status pins");
    a_unmapped_zero: assert property (wb_ack && !we_q && adr_q[8] && adr_q != ADR_STATUS
        |-> wb_dat_r == '0)
        else $error("unmapped read not zero");
    a_scan_steady: assert property ($changed(input_status)
        |=> $stable(input_status)[*8])
        else $error("status moved between scans");
    a_reset_quiet: assert property ($rose(nrst) |-> (input_status == '0)[*8])
        else $error("status active right after reset");
endmodule

bind iic_top iic_monitor #(.N_CH(N_CH), .SCAN_CYC(SCAN_CYC)) u_mon (
    .clock(clock), .nrst(nrst), .volt_mv(volt_mv), .input_status(input_status),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

// file: tb/iic_field_model.sv
// Field voltage source feeding the measured channel inputs
`timescale 1ns/1ps
module iic_field_model
    import iic_pkg::*;
#(
    parameter int N_CH = CHANNELS
) (
    // Clock
    input  wire logic                        clock,
    // Requested and applied levels, mV
    input  wire logic [N_CH-1:0][VOLT_W-1:0] set_mv,
    output logic      [N_CH-1:0][VOLT_W-1:0] volt_mv
);
    // Levels move only on an edge so the scan never sees a half update
    always_ff @(posedge clock) begin
        volt_mv <= set_mv;
    end
endmodule

// file: tb/tb_isolated_input_conditioner.sv
// Self-checking bench for the isolated input conditioner
`timescale 1ns/1ps
module tb_isolated_input_conditioner
    import iic_pkg::*;
;
    localparam int SCAN = 20;
    logic                            clock = 1'b0;
    logic                            nrst = 1'b0;
    logic [CHANNELS-1:0][VOLT_W-1:0] set_mv = '0;
    logic [CHANNELS-1:0][VOLT_W-1:0] volt_mv;
    logic                            wb_cyc = 1'b0;
    logic                            wb_stb = 1'b0;
    logic                            wb_we = 1'b0;
    logic [8:0]                      wb_adr = '0;
    logic [3:0]                      wb_sel = 4'hF;
    logic [31:0]                     wb_dat_w = '0;
    logic [31:0]                     wb_dat_r;
    logic                            wb_ack;
    logic [CHANNELS-1:0]             input_status;
    int                              bad_count = 0;
    int                              comparisons = 0;

    always #25 clock = ~clock;

    iic_field_model u_field (.clock(clock), .set_mv(set_mv), .volt_mv(volt_mv));

    iic_top #(.SCAN_CYC(SCAN)) u_dut (
        .clock(clock), .nrst(nrst), .volt_mv(volt_mv), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .input_status(input_status));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; waits for the answer, never assumes its latency
    task automatic bus(input logic we, input logic [8:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_dat_r;
        if (n >= 50) bad_count++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    function automatic logic [8:0] at(input int ch, input logic [4:0] o);
        return 9'(ch * 32) | {4'h0, o};
    endfunction

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        check(nm, q, exp);
    endtask

    task automatic scans(input int n);
        repeat (n * SCAN) @(posedge clock);
    endtask

    task automatic st(input int ch, input logic exp);
        check("status", {31'h0000_0000, input_status[ch]}, {31'h0000_0000, exp});
    endtask

    task automatic t_defaults();
        for (int ch = 0; ch < CHANNELS; ch++) begin
            rd_chk("ctrl", at(ch, OFS_CTRL), 32'h0000_0000);
            rd_chk("pickup", at(ch, OFS_PICKUP), 32'h0000_0370);
            rd_chk("dropout", at(ch, OFS_DROPOUT), 32'h0000_0258);
            rd_chk("up delay", at(ch, OFS_UP_DLY), 32'h0000_0000);
            rd_chk("down delay", at(ch, OFS_DOWN_DLY), 32'h0000_0000);
            rd_chk("count", at(ch, OFS_COUNT), 32'h0000_0000);
        end
        wr(at(0, OFS_COUNT), 32'h0000_0005);
        rd_chk("count ro", at(0, OFS_COUNT), 32'h0000_0000);
        rd_chk("unmapped", 9'h1F0, 32'h0000_0000);
    endtask

    // Normally open: strict levels, hysteresis, counting and clearing
    task automatic t_open();
        set_mv[0] <= 19'h1_57C0;
        scans(3);
        st(0, 1'b0);
        set_mv[0] <= 19'h1_5824;
        scans(3);
        st(0, 1'b1);
        set_mv[0] <= 19'h1_1170;
        scans(3);
        st(0, 1'b1);
        set_mv[0] <= 19'h0_E9FC;
        scans(3);
        st(0, 1'b0);
        rd_chk("count", at(0, OFS_COUNT), 32'h0000_0001);
        wr(at(0, OFS_CLEAR), 32'h0000_0001);
        rd_chk("cleared", at(0, OFS_COUNT), 32'h0000_0000);
    endtask

    task automatic t_closed();
        wr(at(1, OFS_CTRL), 32'h0000_0001);
        scans(3);
        st(1, 1'b1);
        set_mv[1] <= 19'h1_86A0;
        scans(3);
        st(1, 1'b0);
    endtask

    task automatic t_levels_delays();
        wr(at(2, OFS_PICKUP), 32'h0000_00C8);
        wr(at(4, OFS_UP_DLY), 32'h0000_0014);
        wr(at(4, OFS_DOWN_DLY), 32'h0000_0014);
        set_mv[2] <= 19'h0_7530;
        set_mv[3] <= 19'h0_7530;
        set_mv[4] <= 19'h1_86A0;
        set_mv[5] <= 19'h1_86A0;
        scans(3);
        st(2, 1'b1);
        st(3, 1'b0);
        st(5, 1'b1);
        st(4, 1'b0);
        scans(5);
        st(4, 1'b1);
        set_mv[4] <= '0;
        set_mv[5] <= '0;
        scans(3);
        st(5, 1'b0);
        st(4, 1'b1);
        scans(5);
        st(4, 1'b0);
        // A short pulse that reverts before the pickup delay must leave no trace
        set_mv[4] <= 19'h1_86A0;
        scans(2);
        set_mv[4] <= '0;
        scans(8);
        st(4, 1'b0);
        rd_chk("glitch count", at(4, OFS_COUNT), 32'h0000_0001);
    endtask

    // AC option: low release level and longer fall
    task automatic t_alternating();
        wr(at(6, OFS_CTRL), 32'h0000_0002);
        set_mv[6] <= 19'h1_86A0;
        scans(3);
        st(6, 1'b1);
        set_mv[6] <= 19'h0_7530;
        scans(10);
        st(6, 1'b1);
        set_mv[6] <= 19'h0_1388;
        scans(4);
        st(6, 1'b1);
        scans(6);
        st(6, 1'b0);
        set_mv[7] <= 19'h4_3238;
        scans(1);
        rd_chk("voltage", at(7, OFS_VOLT), 32'h0004_3238);
        // Let channel 7 settle; only channels 2 and 7 are active now
        scans(2);
        rd_chk("status word", ADR_STATUS, 32'h0000_0084);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        t_defaults();
        t_open();
        t_closed();
        t_levels_delays();
        t_alternating();
        print_verdict();
    end

    // Watchdog well beyond the expected run of about 1600 cycles
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end
endmodule
